// File: scan_tap.sv
/*
  Test access port: state machine, instruction register, bypass, identity and
  boundary-scan registers, output forcing. The test clock is sampled by the
  system clock, which must run several times faster than it.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Identity instruction captures 32-bit fixed value.
// - Identity register shifts out bit zero first.
// - Capture-IR loads 01 into low bits.
// - Shift-IR places instruction register on path.
// - New instruction acts only at Update-IR.
// - Code 111 selects the bypass bit.
// - Code 100 samples pins into boundary register.
// - Pinless cells capture their fixed default.
// - Code 000 selects external test with boundary register.
// - External test never blocks input pins.
// - External test drives outputs on update falling edge.
// - External test captures pins on rising edge.
// - Reset and power-up select identity instruction.
// - Code 010 floats outputs, selects boundary register.
// - Codes 011 and 110 act as bypass.
// - Sampling instruction shifts boundary register in Shift-DR.
// - Instruction register is three bits wide.
// - Bypass register is one flip-flop.
// - Five high mode-select edges reach reset state.
// - Inputs sampled rising, data out changes falling.
module scan_tap
  import tap_pkg::*;
(
  input  wire logic             sys_clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             tck_in,
  input  wire logic             tms_in,
  input  wire logic             tdi_in,
  input  wire logic [PIN_W-1:0] pin_level_in,
  input  wire logic [PIN_W-1:0] core_out_in,
  output logic                  tdo_out,
  output logic                  tdo_oe_n_out,
  output logic [PIN_W-1:0]      pin_out,
  output logic                  pin_oe_n_out,
  output logic                  core_follows_pins_out
);

  logic [2:0]         tck_sync_r;
  logic [1:0]         tms_sync_r;
  logic [1:0]         tdi_sync_r;
  logic [PIN_W-1:0]   pin_meta_r;
  logic [PIN_W-1:0]   pin_sync_r;
  logic               rise;
  logic               fall;
  logic               tms_s;
  logic               tdi_s;
  tap_state_t         state_r;
  tap_state_t         state_nxt;
  logic               reset_st;
  logic               cap_dr_st;
  logic               shift_dr_st;
  logic               upd_dr_st;
  logic               cap_ir_st;
  logic               shift_ir_st;
  logic               upd_ir_st;
  logic               enter_reset;
  logic [IR_W-1:0]    ir_shift_r;
  logic [IR_W-1:0]    ir_r;
  logic               bypass_r;
  logic [ID_W-1:0]    id_r;
  logic [BSR_W-1:0]   bsr_r;
  logic [PIN_W-1:0]   upd_r;
  logic               tdo_r;
  logic               tdo_oe_n_r;
  logic               ext_drive;
  logic               sel_bsr;
  logic               sel_id;
  logic               sel_bypass;
  logic               dr_bit;
  logic               serial_bit;
  logic [BSR_W-1:0]   bsr_capture;

  // The first stage of each synchroniser feeds only its second stage.
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tck_sync_r <= 3'h0;
      tms_sync_r <= 2'h3;
      tdi_sync_r <= 2'h3;
    end
    else
    begin
      tck_sync_r <= {tck_sync_r[1:0], tck_in};
      tms_sync_r <= {tms_sync_r[0], tms_in};
      tdi_sync_r <= {tdi_sync_r[0], tdi_in};
    end
  end

  // Pin levels pass the same two stages as the test clock, so a capture sees
  // them as they stood when the rising edge reached the pin.
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end
    else
    begin
      pin_meta_r <= pin_level_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Mode select and data are taken at the same depth as the clock they ride on.
  assign tms_s = tms_sync_r[1];
  assign tdi_s = tdi_sync_r[1];
  // Each test clock edge gives a pulse of one system clock. A half period
  // shorter than one system clock can be missed altogether.
  assign rise  = tck_sync_r[1] & ~tck_sync_r[2];
  assign fall  = ~tck_sync_r[1] & tck_sync_r[2];

  // Instruction decode; unlisted codes fall back on the bypass bit.
  function automatic logic uses_bsr(input logic [IR_W-1:0] op);
    case (op)
      OP_EXTEST:   uses_bsr = 1'b1;
      OP_SAMPLE_Z: uses_bsr = 1'b1;
      OP_SAMPLE:   uses_bsr = 1'b1;
      default:     uses_bsr = 1'b0;
    endcase
  endfunction : uses_bsr

  // The active instruction alone picks the data register; a code still being
  // shifted in has no say until it is updated.
  assign sel_bsr    = uses_bsr(ir_r);
  assign sel_id     = (ir_r == OP_IDCODE);
  assign sel_bypass = ~sel_bsr & ~sel_id;

  // State decodes shared by the register processes below.
  assign reset_st    = (state_r == ST_RESET);
  assign cap_dr_st   = (state_r == ST_CAP_DR);
  assign shift_dr_st = (state_r == ST_SHIFT_DR);
  assign upd_dr_st   = (state_r == ST_UPD_DR);
  assign cap_ir_st   = (state_r == ST_CAP_IR);
  assign shift_ir_st = (state_r == ST_SHIFT_IR);
  assign upd_ir_st   = (state_r == ST_UPD_IR);
  assign enter_reset = rise & (state_nxt == ST_RESET);

  // Serial path: the instruction register in Shift-IR, else the data register.
  assign dr_bit     = sel_bsr ? bsr_r[0] :
                      sel_id  ? id_r[0] : bypass_r;
  assign serial_bit = shift_ir_st ? ir_shift_r[0] : dr_bit;

  // Pinless cells sit in the top bits and always capture their default.
  assign bsr_capture = {BSR_DEFAULT, pin_sync_r};

  // Sixteen-state controller; five rising edges with mode select high reach
  // Test-Logic-Reset from any state, which stands in for a reset pin.
  always_comb
  begin
    state_nxt = ST_RESET;
    case (state_r)
      ST_RESET:    state_nxt = tms_s ? ST_RESET : ST_IDLE;
      ST_IDLE:     state_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR:   state_nxt = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR:   state_nxt = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: state_nxt = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: state_nxt = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: state_nxt = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: state_nxt = tms_s ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR:   state_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR:   state_nxt = tms_s ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR:   state_nxt = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: state_nxt = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: state_nxt = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: state_nxt = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: state_nxt = tms_s ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR:   state_nxt = tms_s ? ST_SEL_DR : ST_IDLE;
      default:     state_nxt = ST_RESET;
    endcase
  end

  // Controller state advances on each rising edge of the test clock.
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= ST_RESET;
    end
    else if (rise)
    begin
      state_r <= state_nxt;
    end
  end

  // Instruction shift stage: captures the fixed pattern, then shifts in from
  // the top towards the serial output.
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ir_shift_r <= OP_IDCODE;
    end
    else if (rise)
    begin
      if (cap_ir_st)
      begin
        ir_shift_r <= IR_CAPTURE;
      end
      else if (shift_ir_st)
      begin
        ir_shift_r <= {tdi_s, ir_shift_r[IR_W-1:1]};
      end
    end
  end

  // Active instruction. It changes on the falling edge in Update-IR, so that
  // selection and pin drive switch together, and it goes back to the identity
  // code on the rising edge that enters Test-Logic-Reset.
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ir_r <= OP_IDCODE;
    end
    else if (enter_reset)
    begin
      ir_r <= OP_IDCODE;
    end
    else if (fall && upd_ir_st)
    begin
      ir_r <= ir_shift_r;
    end
  end

  // Bypass bit: cleared on capture, then one stage of delay while shifting.
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      bypass_r <= 1'b0;
    else if (rise && cap_dr_st)
      bypass_r <= 1'b0;
    else if (rise && shift_dr_st && sel_bypass)
      bypass_r <= tdi_s;
  end

  // Identity register: loads the fixed value, shifts out bit zero first.
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      id_r <= '0;
    else if (rise && cap_dr_st && sel_id)
      id_r <= ID_VALUE;
    else if (rise && shift_dr_st && sel_id)
      id_r <= {tdi_s, id_r[ID_W-1:1]};
  end

  // Boundary register: pins and defaults in parallel, then serial. The pins
  // themselves are never blocked, so the core keeps following them.
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      bsr_r <= '0;
    else if (rise && cap_dr_st && sel_bsr)
      bsr_r <= bsr_capture;
    else if (rise && shift_dr_st && sel_bsr)
      bsr_r <= {tdi_s, bsr_r[BSR_W-1:1]};
  end

  // Serial output and its enable move only on falling edges.
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tdo_r      <= 1'b0;
      tdo_oe_n_r <= 1'b1;
    end
    else if (fall)
    begin
      tdo_r      <= serial_bit;
      tdo_oe_n_r <= ~(shift_dr_st | shift_ir_st);
    end
  end

  // Update latch for the pin drivers; it also takes a preload under the
  // sampling codes, so external test can start from a known pattern.
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      upd_r <= '0;
    else if (fall && upd_dr_st && sel_bsr)
      upd_r <= bsr_r[PIN_W-1:0];
  end

  // Test drive follows the active instruction, which changes on the falling edge
  // in Update-IR and on the rising edge into Test-Logic-Reset, so the pins switch over on those edges.
  assign ext_drive = (ir_r == OP_EXTEST);

  assign tdo_out               = tdo_r;
  assign tdo_oe_n_out          = tdo_oe_n_r;
  // Outside external test the core's own data passes straight through.
  assign pin_out               = ext_drive ? upd_r : core_out_in;
  // The pad ring floats every memory output while this enable is high.
  assign pin_oe_n_out          = (ir_r == OP_SAMPLE_Z);
  assign core_follows_pins_out = 1'b1;

endmodule : scan_tap

`default_nettype wire

// File: tap_pkg.sv
/*
  Constants and types for the boundary-scan test access port of a burst memory.
  Assumes a single system clock that oversamples the test clock.
*/
package tap_pkg;

  localparam int           IR_W          = 3;
  localparam logic [2:0]   IR_CAPTURE    = 3'h1;
  localparam logic [2:0]   OP_EXTEST     = 3'h0;
  localparam logic [2:0]   OP_IDCODE     = 3'h1;
  localparam logic [2:0]   OP_SAMPLE_Z   = 3'h2;
  localparam logic [2:0]   OP_RSVD_A     = 3'h3;
  localparam logic [2:0]   OP_SAMPLE     = 3'h4;
  localparam logic [2:0]   OP_PRIVATE    = 3'h5;
  localparam logic [2:0]   OP_RSVD_B     = 3'h6;
  localparam logic [2:0]   OP_BYPASS     = 3'h7;
  localparam int           ID_W          = 32;
  // Arbitrary identification value; only bit 0 (presence marker) is meaningful.
  localparam logic [31:0]  ID_VALUE      = 32'h0000_0001;
  localparam int           BSR_W         = 8;
  localparam int           PIN_W         = 6;
  localparam logic [1:0]   BSR_DEFAULT   = 2'h3;

  typedef enum logic [15:0] {
    ST_RESET    = 16'h0001,
    ST_IDLE     = 16'h0002,
    ST_SEL_DR   = 16'h0004,
    ST_CAP_DR   = 16'h0008,
    ST_SHIFT_DR = 16'h0010,
    ST_EXIT1_DR = 16'h0020,
    ST_PAUSE_DR = 16'h0040,
    ST_EXIT2_DR = 16'h0080,
    ST_UPD_DR   = 16'h0100,
    ST_SEL_IR   = 16'h0200,
    ST_CAP_IR   = 16'h0400,
    ST_SHIFT_IR = 16'h0800,
    ST_EXIT1_IR = 16'h1000,
    ST_PAUSE_IR = 16'h2000,
    ST_EXIT2_IR = 16'h4000,
    ST_UPD_IR   = 16'h8000
  } tap_state_t;

endpackage : tap_pkg

// File: scan_tap_asserts.sv
/* Port checker for scan_tap, bound to every instance.
   Assumes the test clock holds each phase for several system clocks. */
`timescale 1ns/1ps
`default_nettype none
module scan_tap_asserts
  import tap_pkg::*;
(
  input wire logic             sys_clk_in,
  input wire logic             rst_n_in,
  input wire logic             tck_in,
  input wire logic             tms_in,
  input wire logic [PIN_W-1:0] core_out_in,
  input wire logic             tdo_out,
  input wire logic             tdo_oe_n_out,
  input wire logic [PIN_W-1:0] pin_out,
  input wire logic             pin_oe_n_out,
  input wire logic             core_follows_pins_out
);
  logic [2:0] hi_r;
  // Saturating count of mode-select-high rises, so a long run never wraps back to five.
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
    if (!rst_n_in)
      hi_r <= 3'h0;
    else if ($rose(tck_in))
      hi_r <= tms_in ? hi_r + 3'(hi_r != 3'h7) : 3'h0;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  follow_pins_a: assert property (core_follows_pins_out) else $error("core blocked");
  tdo_fall_a: assert property ($changed(tdo_out) |-> !$past(tck_in))
    else $error("tdo moved with clock high");
  oe_fall_a: assert property ($changed(tdo_oe_n_out) |-> !$past(tck_in))
    else $error("tdo enable moved with clock high");
  tdo_hold_a: assert property ($rose(tck_in) |=> $stable(tdo_out)[*3])
    else $error("tdo moved after rise");
  reset_vals_a: assert property ($rose(rst_n_in) |->
    tdo_oe_n_out && !pin_oe_n_out && pin_out == core_out_in) else $error("bad reset outputs");
  tms_reset_a: assert property ($rose(hi_r == 3'h5) |-> ##6 !pin_oe_n_out && tdo_oe_n_out)
    else $error("no reset after five highs");
  ir_update_a: assert property ($changed(pin_oe_n_out) |-> tdo_oe_n_out)
    else $error("instruction acted during shift");
  drive_upd_a: assert property ($changed(pin_out) && $stable(core_out_in) |-> tdo_oe_n_out)
    else $error("pins driven during shift");
endmodule : scan_tap_asserts
bind scan_tap scan_tap_asserts chk_u (.sys_clk_in, .rst_n_in, .tck_in, .tms_in, .core_out_in,
  .tdo_out, .tdo_oe_n_out, .pin_out, .pin_oe_n_out, .core_follows_pins_out);
`default_nettype wire

// File: scan_host.sv
/* Scan controller model driving the test port.
   Assumes calls start one nanosecond after a system clock edge. */
`timescale 1ns/1ps
`default_nettype none
module scan_host (
  input  wire logic sys_clk_in,
  input  wire logic tdo_in,
  output logic      tck_out,
  output logic      tms_out,
  output logic      tdi_out
);
  initial {tck_out, tms_out, tdi_out} = 3'h3;
  // Mode and data settle a cycle before the rise; tdo is read just before it, long after the fall.
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    {tms_out, tdi_out} = {tms, tdi};
    @(posedge sys_clk_in) #1 tdo = tdo_in;
    tck_out = 1'b1;
    repeat (4) @(posedge sys_clk_in);
    #1 tck_out = 1'b0;
    repeat (3) @(posedge sys_clk_in);
    #1;
  endtask : step
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] q);
    logic b;
    q = 32'h0;
    step(1'b1, 1'b1, b);
    if (ir) step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
    step(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], b);
      q[i] = b;
    end
    step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask : scan
  task automatic reset_tap();
    logic b;
    repeat (5) step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask : reset_tap
endmodule : scan_host
`default_nettype wire

// File: boundary_scan_tap_instructions_tb_top.sv
/* Testbench for scan_tap: identity, every instruction code and pin drive.
   Assumes scan_host drives the test port. */
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_tap_instructions_tb_top;
  import tap_pkg::*;
  logic             sys_clk_in = 1'b0, rst_n_in = 1'b0, tck, tms, tdi, tdo, oe_n, pz_n, fol;
  logic [PIN_W-1:0] pins = 6'h00, core = 6'h2a, pout;
  logic [31:0]      got;
  int               n_mismatch = 0, checked = 0;
  always #50 sys_clk_in = ~sys_clk_in;
  scan_tap dut_u (.sys_clk_in, .rst_n_in, .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
    .pin_level_in(pins), .core_out_in(core), .tdo_out(tdo), .tdo_oe_n_out(oe_n),
    .pin_out(pout), .pin_oe_n_out(pz_n), .core_follows_pins_out(fol));
  scan_host host_u (.sys_clk_in, .tdo_in(tdo), .tck_out(tck), .tms_out(tms), .tdi_out(tdi));
  task automatic check(input logic [31:0] e, input logic [31:0] a);
    checked++;
    if (a !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: expected %h got %h", $time, e, a);
    end
  endtask : check
  task automatic results();
    if (n_mismatch == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  task automatic id_scan();
    host_u.scan(1'b0, 32, 32'hffff_ffff, got);
    check(ID_VALUE, got);
  endtask : id_scan
  task automatic all_codes();
    for (int c = 0; c < 8; c++)
    begin
      pins = 6'(c * 9 + 5);
      host_u.scan(1'b1, 3, 32'(c), got);
      check(32'(IR_CAPTURE), got);
      check(32'(c == 2), 32'(pz_n));
      host_u.scan(1'b0, 8, 32'h96, got);
      check(32'(c == 0 ? 6'h16 : core), 32'(pout));
      if (c == 1) check(32'(ID_VALUE[7:0]), got);
      else if (c[0] || c == 6) check(32'h16, got >> 1);
      else check(32'({2'h3, pins}), got);
    end
  endtask : all_codes
  task automatic extest_drive();
    host_u.scan(1'b1, 3, 32'(OP_SAMPLE), got);
    host_u.scan(1'b0, 8, 32'h3c, got);
    check(32'(core), 32'(pout));
    host_u.scan(1'b1, 3, 32'(OP_EXTEST), got);
    check(32'h3c, 32'(pout));
    check(32'h1, 32'(fol));
    host_u.reset_tap();
    check(32'(core), 32'(pout));
    id_scan();
  endtask : extest_drive
  initial
  begin
    repeat (6) @(posedge sys_clk_in);
    #1 rst_n_in = 1'b1;
    host_u.reset_tap();
    id_scan();
    all_codes();
    extest_drive();
    results();
  end
  initial
  begin
    repeat (50000) @(posedge sys_clk_in);
    n_mismatch++;
    results();
  end
endmodule : boundary_scan_tap_instructions_tb_top
`default_nettype wire
